/* shared/uspp_defines.vh */
// constants of the serial status port: addresses, fields, codes and timing
`ifndef USPP_DEFINES_VH
`define USPP_DEFINES_VH

// ***************************************************************
// timing
// ***************************************************************
`define USPP_CLK_PERIOD_NS 20
`define USPP_INT_HOLD_NS 1000000
`define USPP_INT_HOLD_CYCLES (`USPP_INT_HOLD_NS / `USPP_CLK_PERIOD_NS)

// ***************************************************************
// slave address and transfer framing
// ***************************************************************
`define USPP_ADDR_HIGH 5'h1A
`define USPP_BITS_PER_BYTE 4'h8
`define USPP_REG_SEL_W 4

// ***************************************************************
// register map
// ***************************************************************
`define USPP_REG_DEVICE_STATUS 4'h0
`define USPP_REG_CONFIG 4'h1
`define USPP_READ_INVALID 8'hFF
`define USPP_CONFIG_RESET 8'h20

// ***************************************************************
// device status fields
// ***************************************************************
`define USPP_ST_COMP 0
`define USPP_ST_STICKY 1
`define USPP_ST_SWITCH 2
`define USPP_ST_LIMIT 3
`define USPP_ST_DONE 4
`define USPP_ST_CODE_LO 5
`define USPP_ST_CODE_HI 7

// ***************************************************************
// configuration fields
// ***************************************************************
`define USPP_CFG_CLOSE_REQ 0
`define USPP_CFG_MANUAL 2

// ***************************************************************
// detected source codes
// ***************************************************************
`define USPP_CODE_DCP 3'h1
`define USPP_CODE_CDP 3'h2

`endif

/* design/uspp_sync2.v */
// two-flop synchroniser for levels entering the system clock domain
`timescale 1ns/1ns
`default_nettype none

module uspp_sync2 #(
    parameter WIDTH = 1
) (
    // clock, reset and enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // levels
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] sync_reg;

// the first stage feeds only the second one
always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        meta_reg <= {WIDTH{1'b0}};
        sync_reg <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
        meta_reg <= d_i;
        sync_reg <= meta_reg;
    end
end

assign q_o = sync_reg;

endmodule // uspp_sync2

`default_nettype wire

/* design/uspp_int_hold.v */
// hold timer for the interrupt line: low until timeout or status read
`timescale 1ns/1ns
`default_nettype none

module uspp_int_hold #(
    parameter HOLD_CYCLES = 50000,
    parameter CNT_W = 16
) (
    // clock, reset, enable and clear
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire clear_i,
    // events
    input wire trigger_i,
    input wire status_read_i,
    output wire active_o
);

// the last count is cut to the counter width on purpose
localparam [31:0] LAST_FULL = HOLD_CYCLES - 1;
localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0];

reg active_reg;
reg [CNT_W-1:0] count_reg;

always @(posedge clk_i or posedge rst_i)
begin
    if (rst_i)
    begin
        active_reg <= 1'b0;
        count_reg <= {CNT_W{1'b0}};
    end
    else if (ce_i)
    begin
        if (clear_i)
        begin
            active_reg <= 1'b0;
            count_reg <= {CNT_W{1'b0}};
        end
        // a new event restarts the hold and wins over a read
        else if (trigger_i)
        begin
            active_reg <= 1'b1;
            count_reg <= {CNT_W{1'b0}};
        end
        else if (active_reg)
        begin
            if (status_read_i || count_reg == LAST)
                active_reg <= 1'b0;
            count_reg <= count_reg + 1'b1;
        end
    end
end

assign active_o = active_reg;

endmodule // uspp_int_hold

`default_nettype wire

/* design/uspp_status_port.v */
// serial slave port with device status, configuration and interrupt line
`timescale 1ns/1ns
`default_nettype none
`include "uspp_defines.vh"

module uspp_status_port #(
    parameter INT_HOLD_CYCLES = `USPP_INT_HOLD_CYCLES,
    parameter INT_CNT_W = 16,
    parameter DEAD_BATTERY_VARIANT = 1
) (
    // clock, reset, enable
    input wire CLK_SYS_I,
    input wire RESET_I,
    input wire CLK_EN_I,
    // serial bus pins
    input wire SCL_I,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE_O,
    // interrupt pin, open drain
    output wire INT_N_O,
    output wire INT_N_OE_O,
    // analogue and detector state
    input wire VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I,
    input wire VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I,
    input wire PROTECT_SWITCH_OPEN_I,
    input wire LIMIT_100MA_ACTIVE_I,
    input wire DETECTION_DONE_I,
    input wire [2:0] DETECTED_SOURCE_CODE_I,
    input wire CHARGING_PORT_DISCRIMINATION_ON_I,
    input wire [1:0] ADDR_OTP_I,
    // configuration outputs
    output wire PROTECT_SWITCH_CLOSE_REQUEST_O,
    output wire SWITCH_MANUAL_CONTROL_O,
    output wire LIMIT_100MA_ENABLE_O,
    output wire [7:0] CONFIG_O
);

// ***************************************************************
// states of the transfer engine
// ***************************************************************
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_DEV = 4'h1;
localparam [3:0] ST_DEV_ACK = 4'h2;
localparam [3:0] ST_REG = 4'h3;
localparam [3:0] ST_REG_ACK = 4'h4;
localparam [3:0] ST_WDATA = 4'h5;
localparam [3:0] ST_WDATA_ACK = 4'h6;
localparam [3:0] ST_RDATA = 4'h7;
localparam [3:0] ST_RDATA_ACK = 4'h8;

// ***************************************************************
// input synchronisation
// ***************************************************************
localparam SYNC_W = 13;

wire [SYNC_W-1:0] sync_q;
wire scl_s;
wire sda_s;
wire undervoltage_lockout_ok;
wire above_overvoltage_lockout;
wire switch_open;
wire limit_active;
wire det_done;
wire [2:0] det_code;
wire discrim_on;
wire [1:0] addr_otp;

uspp_sync2 #(
    .WIDTH(SYNC_W)
) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .d_i({SCL_I, SDA_I, VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I, VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I,
          PROTECT_SWITCH_OPEN_I, LIMIT_100MA_ACTIVE_I, DETECTION_DONE_I,
          DETECTED_SOURCE_CODE_I, CHARGING_PORT_DISCRIMINATION_ON_I,
          ADDR_OTP_I}),
    .q_o(sync_q)
);

assign {scl_s, sda_s, undervoltage_lockout_ok, above_overvoltage_lockout, switch_open, limit_active,
        det_done, det_code, discrim_on, addr_otp} = sync_q;

// below lockout status, interrupt hold, transfer state and config are held at default
wire off = ~undervoltage_lockout_ok;

// ***************************************************************
// bus edge and condition detection
// ***************************************************************
reg scl_d_reg;
reg sda_d_reg;

always @(posedge CLK_SYS_I or posedge RESET_I)
begin
    if (RESET_I)
    begin
        scl_d_reg <= 1'b1;
        sda_d_reg <= 1'b1;
    end
    else if (CLK_EN_I)
    begin
        scl_d_reg <= scl_s;
        sda_d_reg <= sda_s;
    end
end

wire scl_rise = scl_s & ~scl_d_reg;
wire scl_fall = ~scl_s & scl_d_reg;
wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

// ***************************************************************
// device status assembly
// ***************************************************************
reg sticky_reg;
reg [7:0] status_prev_reg;
reg status_read;

wire comp_flag = ~above_overvoltage_lockout;
wire overvoltage_lockout_event = comp_flag == 1'b0 && status_prev_reg[`USPP_ST_COMP];

// a detector unable to tell the two charging ports apart reports DCP
wire [2:0] code_shown =
    (!discrim_on && det_code == `USPP_CODE_CDP) ?
    `USPP_CODE_DCP : det_code;

wire [7:0] status_live = {code_shown, det_done, limit_active,
                          switch_open, sticky_reg, comp_flag};

always @(posedge CLK_SYS_I or posedge RESET_I)
begin
    if (RESET_I)
    begin
        sticky_reg <= 1'b0;
        status_prev_reg <= 8'h00;
    end
    else if (CLK_EN_I)
    begin
        if (off)
        begin
            sticky_reg <= 1'b0;
            status_prev_reg <= 8'h00;
        end
        else
        begin
            // an event in the read cycle is kept
            if (overvoltage_lockout_event)
                sticky_reg <= 1'b1;
            else if (status_read)
                sticky_reg <= 1'b0;
            status_prev_reg <= status_live;
        end
    end
end

// any change of a live field, or a latched event, raises the line
wire status_change = overvoltage_lockout_event |
    (status_live[`USPP_ST_CODE_HI:`USPP_ST_SWITCH] !=
     status_prev_reg[`USPP_ST_CODE_HI:`USPP_ST_SWITCH]) |
    (status_live[`USPP_ST_COMP] != status_prev_reg[`USPP_ST_COMP]);

wire int_active;

uspp_int_hold #(
    .HOLD_CYCLES(INT_HOLD_CYCLES),
    .CNT_W(INT_CNT_W)
) u_int_hold (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CLK_EN_I),
    .clear_i(off),
    .trigger_i(status_change),
    .status_read_i(status_read),
    .active_o(int_active)
);

// ***************************************************************
// configuration register
// ***************************************************************
reg [7:0] config_reg;

// the dead-battery limit is lifted only once close and manual are set
assign PROTECT_SWITCH_CLOSE_REQUEST_O = config_reg[`USPP_CFG_CLOSE_REQ];
assign SWITCH_MANUAL_CONTROL_O = config_reg[`USPP_CFG_MANUAL];
assign LIMIT_100MA_ENABLE_O = (DEAD_BATTERY_VARIANT != 0) &&
    !(config_reg[`USPP_CFG_CLOSE_REQ] &&
      config_reg[`USPP_CFG_MANUAL]);
assign CONFIG_O = config_reg;

// ***************************************************************
// transfer engine
// ***************************************************************
reg [3:0] state_reg;
reg [3:0] bit_cnt_reg;
reg [7:0] rx_shift_reg;
reg [7:0] tx_shift_reg;
reg [`USPP_REG_SEL_W-1:0] reg_sel_reg;
reg rw_reg;
reg master_nack_reg;
reg sda_low_reg;

wire byte_done = bit_cnt_reg == `USPP_BITS_PER_BYTE;
wire [6:0] own_addr = {`USPP_ADDR_HIGH, addr_otp};
wire [`USPP_REG_SEL_W-1:0] sel_in =
    rx_shift_reg[`USPP_REG_SEL_W-1:0];

reg [7:0] read_byte;

always @*
begin
    case (reg_sel_reg)
        `USPP_REG_DEVICE_STATUS: read_byte = status_live;
        `USPP_REG_CONFIG: read_byte = config_reg;
        default: read_byte = `USPP_READ_INVALID;
    endcase
end

always @*
begin
    status_read = CLK_EN_I && !off && scl_fall &&
        state_reg == ST_REG_ACK && rw_reg &&
        reg_sel_reg == `USPP_REG_DEVICE_STATUS;
end

always @(posedge CLK_SYS_I or posedge RESET_I)
begin
    if (RESET_I)
    begin
        state_reg <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        rx_shift_reg <= 8'h00;
        tx_shift_reg <= 8'hFF;
        reg_sel_reg <= {`USPP_REG_SEL_W{1'b0}};
        rw_reg <= 1'b0;
        master_nack_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        config_reg <= `USPP_CONFIG_RESET;
    end
    else if (CLK_EN_I)
    begin
        if (off)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
            config_reg <= `USPP_CONFIG_RESET;
        end
        else if (stop_cond)
        begin
            state_reg <= ST_IDLE;
            sda_low_reg <= 1'b0;
        end
        else if (start_cond)
        begin
            state_reg <= ST_DEV;
            bit_cnt_reg <= 4'h0;
            sda_low_reg <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state_reg)
                ST_DEV, ST_REG, ST_WDATA:
                begin
                    rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ST_RDATA:
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                ST_RDATA_ACK:
                    master_nack_reg <= sda_s;
                default:
                    bit_cnt_reg <= bit_cnt_reg;
            endcase
        end
        else if (scl_fall)
        begin
            case (state_reg)
                ST_DEV:
                    if (byte_done)
                    begin
                        if (rx_shift_reg[7:1] == own_addr)
                        begin
                            rw_reg <= rx_shift_reg[0];
                            sda_low_reg <= 1'b1;
                            state_reg <= ST_DEV_ACK;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                ST_DEV_ACK:
                begin
                    sda_low_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    state_reg <= ST_REG;
                end
                ST_REG:
                    if (byte_done)
                    begin
                        reg_sel_reg <= sel_in;
                        sda_low_reg <= 1'b1;
                        state_reg <= ST_REG_ACK;
                    end
                ST_REG_ACK:
                begin
                    bit_cnt_reg <= 4'h0;
                    if (rw_reg)
                    begin
                        // first data bit goes out on this same falling edge
                        tx_shift_reg <= read_byte;
                        sda_low_reg <= ~read_byte[7];
                        state_reg <= ST_RDATA;
                    end
                    else
                    begin
                        sda_low_reg <= 1'b0;
                        state_reg <= ST_WDATA;
                    end
                end
                ST_WDATA:
                    if (byte_done)
                    begin
                        if (reg_sel_reg == `USPP_REG_CONFIG)
                            config_reg <= rx_shift_reg;
                        sda_low_reg <= 1'b1;
                        state_reg <= ST_WDATA_ACK;
                    end
                ST_WDATA_ACK:
                begin
                    sda_low_reg <= 1'b0;
                    bit_cnt_reg <= 4'h0;
                    state_reg <= ST_REG;
                end
                ST_RDATA:
                    if (byte_done)
                    begin
                        sda_low_reg <= 1'b0;
                        state_reg <= ST_RDATA_ACK;
                    end
                    else
                    begin
                        tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                        sda_low_reg <= ~tx_shift_reg[6];
                    end
                ST_RDATA_ACK:
                begin
                    bit_cnt_reg <= 4'h0;
                    // nack leaves the bus to the master until its stop
                    state_reg <= master_nack_reg ? ST_IDLE : ST_REG;
                end
                default:
                    sda_low_reg <= 1'b0;
            endcase
        end
    end
end

// ***************************************************************
// pin drivers: open drain, floating below lockout
// ***************************************************************
assign SDA_O = 1'b0;
assign SDA_OE_O = sda_low_reg & undervoltage_lockout_ok;
assign INT_N_O = 1'b0;
assign INT_N_OE_O = int_active & undervoltage_lockout_ok;

endmodule // uspp_status_port

`default_nettype wire

/* test/uspp_status_port_asserts.sv */
// concurrent checks on the pins of the serial status port
`timescale 1ns/1ns
`default_nettype none

module uspp_status_port_asserts #(
    parameter INT_HOLD_CYCLES = 50000
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    // bus and interrupt pins
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic INT_N_O,
    input wire logic INT_N_OE_O,
    // analogue and detector state
    input wire logic VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I,
    input wire logic VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I,
    input wire logic PROTECT_SWITCH_OPEN_I,
    input wire logic LIMIT_100MA_ACTIVE_I,
    input wire logic DETECTION_DONE_I,
    input wire logic [2:0] DETECTED_SOURCE_CODE_I,
    input wire logic CHARGING_PORT_DISCRIMINATION_ON_I,
    // configuration outputs
    input wire logic PROTECT_SWITCH_CLOSE_REQUEST_O,
    input wire logic SWITCH_MANUAL_CONTROL_O,
    input wire logic LIMIT_100MA_ENABLE_O,
    input wire logic [7:0] CONFIG_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    logic [7:0] stat_in;
    logic [7:0] stat_prev_reg;
    logic [31:0] hold_cnt_reg;
    assign stat_in = {DETECTED_SOURCE_CODE_I, DETECTION_DONE_I,
        LIMIT_100MA_ACTIVE_I, PROTECT_SWITCH_OPEN_I, VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I,
        CHARGING_PORT_DISCRIMINATION_ON_I};
    // ****************************************************************
    // interrupt hold counter, restarted by any change of status inputs
    // ****************************************************************
    always @(posedge CLK_SYS_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            stat_prev_reg <= 8'h00;
            hold_cnt_reg <= 32'h0;
        end
        else
        begin
            stat_prev_reg <= stat_in;
            if (!INT_N_OE_O || stat_in != stat_prev_reg)
                hold_cnt_reg <= 32'h0;
            else
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end
    sequence undervoltage_lockout_low_s;
        !VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I [*5];
    endsequence
    chk_sda_open_drain:
    assert property (SDA_O == 1'b0) else $error("data pin drives high");
    chk_int_open_drain:
    assert property (INT_N_O == 1'b0) else $error("interrupt drives high");
    chk_undervoltage_lockout_pins_float:
    assert property (undervoltage_lockout_low_s |-> !SDA_OE_O && !INT_N_OE_O)
        else $error("pins driven below undervoltage lockout");
    chk_undervoltage_lockout_cfg_default:
    assert property (undervoltage_lockout_low_s |-> CONFIG_O == 8'h20)
        else $error("config not default below undervoltage lockout");
    chk_limit_bypass:
    assert property (LIMIT_100MA_ENABLE_O == !(CONFIG_O[0] && CONFIG_O[2]))
        else $error("current limit enable wrong");
    chk_cfg_pin_map:
    assert property ({PROTECT_SWITCH_CLOSE_REQUEST_O, SWITCH_MANUAL_CONTROL_O}
        == {CONFIG_O[0], CONFIG_O[2]}) else $error("config pins wrong");
    chk_int_hold_bound:
    assert property (hold_cnt_reg <= INT_HOLD_CYCLES + 8)
        else $error("interrupt held too long");
    chk_sda_scl_low:
    assert property ($changed(SDA_OE_O) && VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I &&
        $past(VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I, 3) |-> !SCL_I)
        else $error("data changed while bus clock high");
endmodule // uspp_status_port_asserts

bind uspp_status_port uspp_status_port_asserts #(
    .INT_HOLD_CYCLES(INT_HOLD_CYCLES)
) i_uspp_status_port_asserts (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .INT_N_O(INT_N_O),
    .INT_N_OE_O(INT_N_OE_O), .VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I(VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I),
    .VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I(VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I),
    .PROTECT_SWITCH_OPEN_I(PROTECT_SWITCH_OPEN_I),
    .LIMIT_100MA_ACTIVE_I(LIMIT_100MA_ACTIVE_I),
    .DETECTION_DONE_I(DETECTION_DONE_I),
    .DETECTED_SOURCE_CODE_I(DETECTED_SOURCE_CODE_I),
    .CHARGING_PORT_DISCRIMINATION_ON_I(CHARGING_PORT_DISCRIMINATION_ON_I),
    .PROTECT_SWITCH_CLOSE_REQUEST_O(PROTECT_SWITCH_CLOSE_REQUEST_O),
    .SWITCH_MANUAL_CONTROL_O(SWITCH_MANUAL_CONTROL_O),
    .LIMIT_100MA_ENABLE_O(LIMIT_100MA_ENABLE_O), .CONFIG_O(CONFIG_O)
);
`default_nettype wire

/* test/uspp_i2c_master_model.sv */
// bus master model: 160 ns bus clock, open-drain data, idle clock high
`timescale 1ns/1ns
`default_nettype none

module uspp_i2c_master_model (
    // timing reference
    input wire logic clk_i,
    // bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic bit_out(input logic b);
        sda_low_o = !b;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask
    // sample mid-high, well after the device's answer has settled
    task automatic bit_in(output logic b);
        sda_low_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        b = sda_i;
        tick(2);
        scl_o = 1'b0;
        tick(2);
    endtask
    // also serves as repeated start from a low clock
    task automatic start();
        sda_low_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b0;
        tick(4);
    endtask
    // msb first, then the ninth bit from the device
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask
    task automatic recv(input logic ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            bit_in(b);
            d[i] = b;
        end
        bit_out(!ack);
    endtask
endmodule // uspp_i2c_master_model
`default_nettype wire

/* test/uspp_status_port_tb_top.sv */
// self-checking bench for the serial status port
`timescale 1ns/1ns
`default_nettype none

module uspp_status_port_tb_top;
    localparam int HOLD = 2000;
    logic clk = 1'b0;
    logic rst, undervoltage_lockout, overvoltage_lockout, sw_open, lim, done, disc, ack;
    logic [2:0] code;
    logic [1:0] otp;
    logic scl, m_low, sda_o, sda_oe, int_o, int_oe, lim_en, close_req, manual;
    logic [7:0] cfg, d0, d1;
    wire sda_line = !(m_low || sda_oe);
    int miscompares = 0;
    int compares = 0;
    int n;
    always #10 clk = !clk;
    uspp_status_port #(.INT_HOLD_CYCLES(HOLD)) i_uspp_status_port (
        .CLK_SYS_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .SCL_I(scl),
        .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .INT_N_O(int_o),
        .INT_N_OE_O(int_oe), .VBUS_ABOVE_UNDERVOLTAGE_LOCKOUT_I(undervoltage_lockout),
        .VBUS_ABOVE_OVERVOLTAGE_LOCKOUT_I(overvoltage_lockout), .PROTECT_SWITCH_OPEN_I(sw_open),
        .LIMIT_100MA_ACTIVE_I(lim), .DETECTION_DONE_I(done),
        .DETECTED_SOURCE_CODE_I(code),
        .CHARGING_PORT_DISCRIMINATION_ON_I(disc), .ADDR_OTP_I(otp),
        .PROTECT_SWITCH_CLOSE_REQUEST_O(close_req),
        .SWITCH_MANUAL_CONTROL_O(manual), .LIMIT_100MA_ENABLE_O(lim_en),
        .CONFIG_O(cfg));
    uspp_i2c_master_model i_uspp_i2c_master_model (.clk_i(clk),
        .sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tx(input logic [7:0] b, input logic exp);
        i_uspp_i2c_master_model.send(b, ack);
        check("ack", {7'h00, exp}, {7'h00, ack});
    endtask
    task automatic wr(input logic [7:0] ra, dt);
        i_uspp_i2c_master_model.start();
        tx({5'h1A, otp, 1'b0}, 1'b1);
        tx(ra, 1'b1);
        tx(dt, 1'b1);
        i_uspp_i2c_master_model.stop();
    endtask
    task automatic rd(input logic [7:0] ra, rb, input logic two);
        i_uspp_i2c_master_model.start();
        tx({5'h1A, otp, 1'b1}, 1'b1);
        tx(ra, 1'b1);
        i_uspp_i2c_master_model.recv(two, d0);
        if (two)
        begin
            tx(rb, 1'b1);
            i_uspp_i2c_master_model.recv(1'b0, d1);
        end
        i_uspp_i2c_master_model.stop();
    endtask
    task automatic wait_int(input logic lvl, input int lim_cyc);
        n = 0;
        while (int_oe !== lvl && n < lim_cyc)
        begin
            @(negedge clk);
            n++;
        end
        check("interrupt", {7'h00, lvl}, {7'h00, int_oe});
        if (int_oe !== lvl)
            stop_test();
    endtask
    // expected status byte built from the detector inputs
    function automatic logic [7:0] st(input logic sticky);
        logic [2:0] c;
        c = (!disc && code == 3'h2) ? 3'h1 : code;
        return {c, done, lim, sw_open, sticky, !overvoltage_lockout};
    endfunction
    initial
    begin
        {rst, undervoltage_lockout, lim, disc, overvoltage_lockout, sw_open, done, code} = 10'h3C0;
        otp = 2'h2;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check("config", 8'h20, cfg);
        check("limit", 8'h01, {7'h00, lim_en});
        wait_int(1'b1, 10);
        rd(8'h00, 8'h00, 1'b0);
        check("status", st(1'b0), d0);
        check("int", 8'h00, {7'h00, int_oe});
        $display("test reset done");
        i_uspp_i2c_master_model.start();
        tx({5'h1A, 2'h0, 1'b0}, 1'b0);
        i_uspp_i2c_master_model.stop();
        wr(8'h01, 8'h05);
        check("config", 8'h05, cfg);
        check("pins", 8'h03, {6'h00, close_req, manual});
        check("limit", 8'h00, {7'h00, lim_en});
        otp = 2'h1;
        wr(8'hF1, 8'h0A);
        check("config", 8'h0A, cfg);
        for (int i = 0; i < 4; i++)
            wr((i == 1) ? 8'h1F : {6'h00, i[1:0]}, 8'h55);
        check("config", 8'h0A, cfg);
        i_uspp_i2c_master_model.start();
        tx({5'h1A, otp, 1'b0}, 1'b1);
        for (int i = 0; i < 2; i++)
            tx(i[0] ? 8'h24 : 8'h01, 1'b1);
        tx(8'h02, 1'b1);
        tx(8'h99, 1'b1);
        i_uspp_i2c_master_model.stop();
        check("config", 8'h24, cfg);
        rd(8'hE1, 8'h03, 1'b1);
        check("read", 8'h24, d0);
        check("read", 8'hFF, d1);
        $display("test register access done");
        for (int c = 0; c < 7; c++)
        begin
            code = (c == 6) ? 3'h2 : c[2:0];
            disc = (c != 6);
            done = (c != 0);
            {lim, sw_open} = c[1:0];
            wait_int(1'b1, 10);
            rd(8'h00, 8'h00, 1'b0);
            check("status", st(1'b0), d0);
        end
        overvoltage_lockout = 1'b1;
        wait_int(1'b1, 10);
        rd(8'h00, 8'h00, 1'b0);
        check("status", st(1'b1), d0);
        check("int", 8'h00, {7'h00, int_oe});
        rd(8'h00, 8'h00, 1'b0);
        check("status", st(1'b0), d0);
        overvoltage_lockout = 1'b0;
        wait_int(1'b1, 10);
        wait_int(1'b0, HOLD + 20);
        check("hold", 8'h01, {7'h00, n > HOLD - 10});
        $display("test status and interrupt done");
        wr(8'h01, 8'h0A);
        undervoltage_lockout = 1'b0;
        repeat (6) @(negedge clk);
        check("config", 8'h20, cfg);
        check("pins", 8'h00, {6'h00, sda_oe, int_oe});
        i_uspp_i2c_master_model.start();
        tx({5'h1A, otp, 1'b0}, 1'b0);
        i_uspp_i2c_master_model.stop();
        undervoltage_lockout = 1'b1;
        repeat (6) @(negedge clk);
        rd(8'h01, 8'h00, 1'b0);
        check("read", 8'h20, d0);
        $display("test undervoltage done");
        stop_test();
    end
endmodule // uspp_status_port_tb_top
`default_nettype wire
